/* File: rcap_rtc.sv */
// RTC with 48-bit counter, alarm compare, 20-bit periodic tick and APB slave
//
// Functional notes
// [R1] Counter increments per tick; alarm on match
// [R2] Tick at most quarter of APB clock
// [R3] 20-bit period register sets periodic interval
// [R4] System reset clears all but time registers
// [R5] RTC reset: alarm ones, period 8000h, count 0
// [R6] Free running after reset; interrupts masked
// [R7] Software clears stale flags before enabling
// [R8] Time registers writable only in config mode
// [R9] Clearing config flag starts staged update
// [R10] Bit 5 reads update done status
// [R11] All writes ignored while update busy
// [R12] Config-clear write: busy 1-2 ticks
// [R13] Word access; reserved bits read zero
// [R14] Control resets to 0020h, enables off
// [R15] Bit 10 periodic, bit 9 alarm enable
// [R16] Control bits 3 and 0 read one
// [R17] Periodic flag bit 2 at threshold
// [R18] Alarm flag bit 1 on match
// [R19] Flags only set by hardware; write 0 clears
// [R20] No alarm flag while system held reset
// [R21] In stop mode alarm after one second
// [R22] Counter slice writes load; reads live
// [R23] Reads return current value while busy
// [R24] Counters run on RTC reset domain only
// [R25] Staged values applied together within two ticks
// [R26] Period counts down, reloads at threshold
// [R27] Zero period holds periodic interrupt high
// [R28] Staged values and trigger handed to tick logic
// [R29] Counter as three 16-bit word registers
`include "rcap_map.svh"
module rcap_rtc #(
   parameter int unsigned TICKS_PER_SEC = `RCAP_TICK_HZ
) (
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        rtc_domain_reset_n,
   input  wire logic        tick_clock,
   input  wire logic        stop_mode,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             alarm_irq,
   output logic             periodic_irq
);
   localparam int unsigned STOP_TICKS = `RCAP_STOP_ALARM_S * TICKS_PER_SEC;

   rcap_pkg::rcap_ctrl_type  ctrl_ff;
   rcap_pkg::rcap_stage_type stage_ff;
   rcap_pkg::rcap_pend_type  pend_ff;
   logic        tickPrev_ff;
   logic [47:0] count_ff;
   logic [47:0] alarm_ff;
   logic [19:0] period_ff;
   logic [19:0] perCnt_ff;
   logic [31:0] stopCnt_ff;
   logic [1:0]  busyCnt_ff;
   logic        applyArm_ff;
   logic        almFlag_ff;
   logic        perFlag_ff;
   logic        tickPulse;
   logic        access;
   logic        wrEn;
   logic        wrCtrl;
   logic        cfgWr;
   logic        applyPulse;
   logic        almEvent;
   logic        perEvent;
   logic        mapped;
   logic [15:0] wd;
   logic [15:0] rdMux;

   // Tick clock is sampled synchronously; its rising edge becomes an enable
   always_ff @(posedge clock or negedge rtc_domain_reset_n) begin
      if (!rtc_domain_reset_n) begin
         tickPrev_ff <= 1'b0;
      end else begin
         tickPrev_ff <= tick_clock;
      end
   end
   assign tickPulse = tick_clock & ~tickPrev_ff; // [R2]

   // APB decode: one wait state, effects committed in the first access cycle
   assign access = psel & penable & ~pready;
   assign wd     = pwdata[15:0];
   assign wrEn   = access & pwrite & ctrl_ff.done; // [R11]
   assign wrCtrl = wrEn & (paddr == `RCAP_OFF_CTRL);
   assign cfgWr  = wrEn & ctrl_ff.config_flag; // [R8]

   // Staged update goes out on the first tick of the busy window
   assign applyPulse = tickPulse & ~ctrl_ff.done & applyArm_ff & (busyCnt_ff == 2'h0); // [R28]

   // Stop mode swaps the compare for a fixed one-second timer
   assign almEvent = tickPulse & (stop_mode ? (stopCnt_ff == STOP_TICKS - 1) // [R21]
                                            : (count_ff == alarm_ff)); // [R1]
   assign perEvent = tickPulse & (perCnt_ff == 20'h0_0000); // [R26]

   // Control register and update sequencer
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_ff     <= '{periodic_irq_enable: 1'b0, almEn: 1'b0, config_flag: 1'b0, done: 1'b1}; // [R4] [R14]
         busyCnt_ff  <= 2'h0;
         applyArm_ff <= 1'b0;
      end else if (wrCtrl) begin
         ctrl_ff.periodic_irq_enable <= wd[`RCAP_BIT_PER_EN]; // [R15]
         ctrl_ff.almEn <= wd[`RCAP_BIT_ALM_EN]; // [R15]
         ctrl_ff.config_flag   <= wd[`RCAP_BIT_CNF];
         if (!wd[`RCAP_BIT_CNF]) begin
            // Busy even without prior config mode, so only control changes then
            ctrl_ff.done <= 1'b0; // [R12]
            busyCnt_ff   <= 2'h0;
            applyArm_ff  <= ctrl_ff.config_flag; // [R9]
         end
      end else if (!ctrl_ff.done && tickPulse) begin
         // Two tick edges give one to two tick periods of busy
         if (busyCnt_ff + 2'h1 == `RCAP_UPDATE_TICKS) begin
            ctrl_ff.done <= 1'b1; // [R25]
            applyArm_ff  <= 1'b0;
         end
         busyCnt_ff <= busyCnt_ff + 2'h1;
      end
   end

   // Staging registers hold config-mode writes until the update
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         stage_ff <= '0;
         pend_ff  <= '0;
      end else if (applyPulse) begin
         pend_ff <= '0;
      end else if (cfgWr) begin
         unique case (paddr)
            `RCAP_OFF_COUNT_SLICE_LOW: begin stage_ff.count[15:0]  <= wd; pend_ff.count[0] <= 1'b1; end
            `RCAP_OFF_COUNT_SLICE_MIDDLE: begin stage_ff.count[31:16] <= wd; pend_ff.count[1] <= 1'b1; end
            `RCAP_OFF_COUNT_SLICE_HIGH: begin stage_ff.count[47:32] <= wd; pend_ff.count[2] <= 1'b1; end
            `RCAP_OFF_ALM_L: begin stage_ff.alarm[15:0]  <= wd; pend_ff.alarm[0] <= 1'b1; end
            `RCAP_OFF_ALM_M: begin stage_ff.alarm[31:16] <= wd; pend_ff.alarm[1] <= 1'b1; end
            `RCAP_OFF_ALM_H: begin stage_ff.alarm[47:32] <= wd; pend_ff.alarm[2] <= 1'b1; end
            `RCAP_OFF_PER_L: begin stage_ff.period[15:0] <= wd; pend_ff.period[0] <= 1'b1; end
            `RCAP_OFF_PER_H: begin stage_ff.period[19:16] <= wd[3:0]; pend_ff.period[1] <= 1'b1; end
            default: begin end
         endcase
      end
   end

   // Time counter; lives on the RTC reset so system reset leaves it running
   always_ff @(posedge clock or negedge rtc_domain_reset_n) begin
      if (!rtc_domain_reset_n) begin
         count_ff <= `RCAP_CNT_RESET; // [R5]
      end else if (applyPulse) begin
         for (int i = 0; i < 3; i++) begin
            if (pend_ff.count[i]) begin
               count_ff[i*16 +: 16] <= stage_ff.count[i*16 +: 16]; // [R22] [R25]
            end
         end
      end else if (tickPulse) begin
         count_ff <= count_ff + 48'h1; // [R1] [R24]
      end
   end

   // Alarm and period values
   always_ff @(posedge clock or negedge rtc_domain_reset_n) begin
      if (!rtc_domain_reset_n) begin
         alarm_ff  <= `RCAP_ALM_RESET; // [R5]
         period_ff <= `RCAP_PER_RESET; // [R5]
      end else if (applyPulse) begin
         for (int i = 0; i < 3; i++) begin
            if (pend_ff.alarm[i]) begin
               alarm_ff[i*16 +: 16] <= stage_ff.alarm[i*16 +: 16]; // [R25]
            end
         end
         if (pend_ff.period[0]) begin
            period_ff[15:0] <= stage_ff.period[15:0]; // [R3]
         end
         if (pend_ff.period[1]) begin
            period_ff[19:16] <= stage_ff.period[19:16]; // [R3]
         end
      end
   end

   // Period down-counter reloads at zero; new period restarts it at once
   always_ff @(posedge clock or negedge rtc_domain_reset_n) begin
      if (!rtc_domain_reset_n) begin
         perCnt_ff <= `RCAP_PER_RESET;
      end else if (applyPulse && pend_ff.period != 2'h0) begin
         perCnt_ff <= {pend_ff.period[1] ? stage_ff.period[19:16] : period_ff[19:16],
                       pend_ff.period[0] ? stage_ff.period[15:0] : period_ff[15:0]};
      end else if (perEvent) begin
         perCnt_ff <= period_ff; // [R26]
      end else if (tickPulse) begin
         perCnt_ff <= perCnt_ff - 20'h1; // [R26]
      end
   end

   // Stop-mode second timer restarts whenever stop mode is left
   always_ff @(posedge clock or negedge rtc_domain_reset_n) begin
      if (!rtc_domain_reset_n) begin
         stopCnt_ff <= 32'h0;
      end else if (!stop_mode || almEvent) begin
         stopCnt_ff <= 32'h0;
      end else if (tickPulse) begin
         stopCnt_ff <= stopCnt_ff + 32'h1; // [R21]
      end
   end

   // Request flags: set wins over clear; held clear while system reset is low
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         almFlag_ff <= 1'b0; // [R20]
         perFlag_ff <= 1'b0;
      end else begin
         almFlag_ff <= almEvent | (almFlag_ff & ~(wrCtrl & ~wd[`RCAP_BIT_ALM_FLAG])); // [R18] [R19]
         perFlag_ff <= perEvent | (perFlag_ff & ~(wrCtrl & ~wd[`RCAP_BIT_PER_FLAG])); // [R17] [R19]
      end
   end

   // Interrupt outputs gated by the enables; zero period forces periodic high
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         alarm_irq    <= 1'b0; // [R6]
         periodic_irq <= 1'b0;
      end else begin
         alarm_irq    <= almFlag_ff & ctrl_ff.almEn; // [R18]
         periodic_irq <= ctrl_ff.periodic_irq_enable & (perFlag_ff | (period_ff == 20'h0_0000)); // [R17] [R27]
      end
   end

   // Read mux returns live values regardless of busy state
   always_comb begin
      rdMux  = 16'h0000; // [R13]
      mapped = 1'b1;
      unique case (paddr)
         `RCAP_OFF_CTRL: begin
            rdMux[`RCAP_BIT_PER_EN]   = ctrl_ff.periodic_irq_enable;
            rdMux[`RCAP_BIT_ALM_EN]   = ctrl_ff.almEn;
            rdMux[`RCAP_BIT_DONE]     = ctrl_ff.done; // [R10] [R23]
            rdMux[`RCAP_BIT_CNF]      = ctrl_ff.config_flag;
            rdMux[`RCAP_BIT_FIX3]     = 1'b1; // [R16]
            rdMux[`RCAP_BIT_PER_FLAG] = perFlag_ff;
            rdMux[`RCAP_BIT_ALM_FLAG] = almFlag_ff;
            rdMux[`RCAP_BIT_FIX0]     = 1'b1; // [R16]
         end
         `RCAP_OFF_COUNT_SLICE_LOW: rdMux = count_ff[15:0]; // [R22] [R29]
         `RCAP_OFF_COUNT_SLICE_MIDDLE: rdMux = count_ff[31:16]; // [R29]
         `RCAP_OFF_COUNT_SLICE_HIGH: rdMux = count_ff[47:32]; // [R29]
         `RCAP_OFF_ALM_L: rdMux = alarm_ff[15:0];
         `RCAP_OFF_ALM_M: rdMux = alarm_ff[31:16];
         `RCAP_OFF_ALM_H: rdMux = alarm_ff[47:32];
         `RCAP_OFF_PER_L: rdMux = perCnt_ff[15:0];
         `RCAP_OFF_PER_H: rdMux = {12'h000, perCnt_ff[19:16]};
         default:         mapped = 1'b0;
      endcase
   end

   // APB answer registers; upper data bits always zero
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready  <= access;
         pslverr <= access & ~mapped;
         if (access && !pwrite) begin
            prdata <= {16'h0000, rdMux}; // [R13] [R23]
         end
      end
   end

   a_done_drops: assert property (@(posedge clock) disable iff (!rst_n) // [R12]
      wrCtrl && !wd[`RCAP_BIT_CNF] |=> !ctrl_ff.done)
      else $error("Update done did not drop after config clear");
   a_busy_blocks_ctrl: assert property (@(posedge clock) disable iff (!rst_n) // [R11]
      !ctrl_ff.done && !tickPulse |=> $stable(ctrl_ff.periodic_irq_enable) && $stable(ctrl_ff.almEn))
      else $error("Control changed while update busy");
   a_done_on_tick: assert property (@(posedge clock) disable iff (!rst_n) // [R25]
      $rose(ctrl_ff.done) |-> $past(tickPulse) && $past(busyCnt_ff) == 2'h1)
      else $error("Update done returned off the second tick");
   a_count_advances: assert property (@(posedge clock) disable iff (!rtc_domain_reset_n) // [R1]
      tickPulse && !applyPulse |=> count_ff == $past(count_ff) + 48'h1)
      else $error("Counter did not advance on tick");
   a_alarm_sets_flag: assert property (@(posedge clock) disable iff (!rst_n) // [R18]
      tickPulse && !stop_mode && count_ff == alarm_ff |=> almFlag_ff)
      else $error("Alarm match did not set flag");
   a_flag_sticky: assert property (@(posedge clock) disable iff (!rst_n) // [R19]
      almFlag_ff && !(wrCtrl && !wd[`RCAP_BIT_ALM_FLAG]) |=> almFlag_ff)
      else $error("Alarm flag cleared without software");
   a_irq_masked: assert property (@(posedge clock) disable iff (!rst_n) // [R15]
      !ctrl_ff.almEn |=> !alarm_irq)
      else $error("Alarm interrupt while masked");
   a_zero_period_high: assert property (@(posedge clock) disable iff (!rst_n) // [R27]
      ctrl_ff.periodic_irq_enable && period_ff == 20'h0_0000 |=> periodic_irq)
      else $error("Zero period did not hold interrupt high");
   a_ctrl_fixed_ones: assert property (@(posedge clock) disable iff (!rst_n) // [R16]
      access && !pwrite && paddr == `RCAP_OFF_CTRL |=> pready && prdata[3] && prdata[0])
      else $error("Control fixed bits not read as one");
   a_stage_blocked: assert property (@(posedge clock) disable iff (!rst_n) // [R8]
      access && pwrite && !ctrl_ff.config_flag && !applyPulse |=> $stable(pend_ff))
      else $error("Staged write accepted outside config mode");

   // Bus answer shape: one-cycle ready, upper half always zero
   a_ready_after_access: assert property (@(posedge clock) disable iff (!rst_n)
      access |=> pready)
      else $error("Access not answered in the next cycle");
   // A held request must not be taken twice
   a_ready_one_cycle: assert property (@(posedge clock) disable iff (!rst_n)
      pready |=> !pready)
      else $error("Ready stood longer than one cycle");
   // Only the low half carries register data
   a_upper_data_zero: assert property (@(posedge clock) disable iff (!rst_n) // [R13]
      pready |-> prdata[31:16] == 16'h0000)
      else $error("Upper read data not zero");
   // Error only ever accompanies an answer
   a_error_with_ready: assert property (@(posedge clock) disable iff (!rst_n) // [R13]
      pslverr |-> pready)
      else $error("Slave error without ready");
   // The control register is always mapped
   a_ctrl_no_error: assert property (@(posedge clock) disable iff (!rst_n) // [R13]
      access && paddr == `RCAP_OFF_CTRL |=> !pslverr)
      else $error("Control access flagged as error");
   // Counter reads see the live value of the access cycle
   a_count_read_live: assert property (@(posedge clock) disable iff (!rst_n) // [R22]
      access && !pwrite && paddr == `RCAP_OFF_COUNT_SLICE_LOW |=> prdata[15:0] == $past(count_ff[15:0]))
      else $error("Counter read not live");
   // Busy window freezes the configuration flag too
   a_busy_keeps_cnf: assert property (@(posedge clock) disable iff (!rst_n) // [R11]
      access && pwrite && !ctrl_ff.done |=> $stable(ctrl_ff.config_flag))
      else $error("Configuration flag changed while busy");
   // Busy window also freezes the staging registers
   a_busy_keeps_stage: assert property (@(posedge clock) disable iff (!rst_n) // [R11]
      access && pwrite && !ctrl_ff.done |=> $stable(stage_ff))
      else $error("Staging changed while busy");
   // Entering config mode starts no update
   a_cnf_enters: assert property (@(posedge clock) disable iff (!rst_n) // [R8]
      wrCtrl && wd[`RCAP_BIT_CNF] |=> ctrl_ff.config_flag && ctrl_ff.done)
      else $error("Config entry did not take effect");
   // Full counter load lands in one edge, whatever the write order
   a_count_applied: assert property (@(posedge clock) disable iff (!rtc_domain_reset_n) // [R25]
      applyPulse && pend_ff.count == 3'h7 |=> count_ff == $past(stage_ff.count))
      else $error("Staged counter not applied");
   // Full alarm load lands together with the counter
   a_alarm_applied: assert property (@(posedge clock) disable iff (!rtc_domain_reset_n) // [R25]
      applyPulse && pend_ff.alarm == 3'h7 |=> alarm_ff == $past(stage_ff.alarm))
      else $error("Staged alarm not applied");
   // Full period load lands together with the counter
   a_period_applied: assert property (@(posedge clock) disable iff (!rtc_domain_reset_n) // [R3]
      applyPulse && pend_ff.period == 2'h3 |=> period_ff == $past(stage_ff.period))
      else $error("Staged period not applied");
   // Down-counter restarts from the period at the threshold
   a_period_reload: assert property (@(posedge clock) disable iff (!rtc_domain_reset_n) // [R26]
      perEvent && !applyPulse |=> perCnt_ff == $past(period_ff))
      else $error("Period counter did not reload");
   // Threshold always leaves a pending request behind
   a_period_sets_flag: assert property (@(posedge clock) disable iff (!rst_n) // [R17]
      perEvent |=> perFlag_ff)
      else $error("Period threshold did not set flag");
   // Periodic request is sticky like the alarm one
   a_per_flag_sticky: assert property (@(posedge clock) disable iff (!rst_n) // [R19]
      perFlag_ff && !(wrCtrl && !wd[`RCAP_BIT_PER_FLAG]) |=> perFlag_ff)
      else $error("Periodic flag cleared without software");
   // Masked periodic output stays low, zero period included
   a_per_irq_masked: assert property (@(posedge clock) disable iff (!rst_n) // [R15]
      !ctrl_ff.periodic_irq_enable |=> !periodic_irq)
      else $error("Periodic interrupt while masked");
   // Enabled pending alarm reaches the pin one clock later
   a_alarm_irq_follows: assert property (@(posedge clock) disable iff (!rst_n) // [R18]
      almFlag_ff && ctrl_ff.almEn |=> alarm_irq)
      else $error("Enabled alarm request not signalled");
   // Stop mode alarm comes from the second timer, not the compare
   a_stop_alarm_flag: assert property (@(posedge clock) disable iff (!rst_n) // [R21]
      tickPulse && stop_mode && stopCnt_ff == STOP_TICKS - 1 |=> almFlag_ff)
      else $error("Stop mode second did not set alarm flag");
endmodule

/* File: rcap_map.svh */
// Register offsets, field positions, reset values and timing counts of the RTC
`ifndef RCAP_MAP_SVH
`define RCAP_MAP_SVH
`define RCAP_ADDR_W          8
`define RCAP_OFF_CTRL        8'h00
`define RCAP_OFF_COUNT_SLICE_LOW       8'h04
`define RCAP_OFF_COUNT_SLICE_MIDDLE       8'h08
`define RCAP_OFF_COUNT_SLICE_HIGH       8'h0c
`define RCAP_OFF_ALM_L       8'h10
`define RCAP_OFF_ALM_M       8'h14
`define RCAP_OFF_ALM_H       8'h18
`define RCAP_OFF_PER_L       8'h1c
`define RCAP_OFF_PER_H       8'h20
`define RCAP_BIT_PER_EN      10
`define RCAP_BIT_ALM_EN      9
`define RCAP_BIT_DONE        5
`define RCAP_BIT_CNF         4
`define RCAP_BIT_FIX3        3
`define RCAP_BIT_PER_FLAG    2
`define RCAP_BIT_ALM_FLAG    1
`define RCAP_BIT_FIX0        0
`define RCAP_CTRL_RESET      16'h0020
`define RCAP_CNT_RESET       48'h0000_0000_0000
`define RCAP_ALM_RESET       48'hffff_ffff_ffff
`define RCAP_PER_RESET       20'h0_8000
`define RCAP_STOP_ALARM_S    1
`define RCAP_TICK_HZ         32768
`define RCAP_UPDATE_TICKS    2'h2
`endif

/* File: rcap_pkg.sv */
// Types shared by the RTC design
package rcap_pkg;
   typedef struct packed {
      logic periodic_irq_enable;
      logic almEn;
      logic config_flag;
      logic done;
   } rcap_ctrl_type;
   typedef struct packed {
      logic [47:0] count;
      logic [47:0] alarm;
      logic [19:0] period;
   } rcap_stage_type;
   typedef struct packed {
      logic [2:0] count;
      logic [2:0] alarm;
      logic [1:0] period;
   } rcap_pend_type;
endpackage

/* File: rcap_apb_master.sv */
// APB master model that issues one transfer at a time towards the RTC
module rcap_apb_master (
   input  wire logic        clock,
   input  wire logic        pready,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle bus at time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
   end

   // Setup, access, hold until pready is seen, then release after its rising edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(negedge clock);
      psel = 1'b1;
      pwrite = w;
      paddr = a;
      pwdata = d;
      @(negedge clock);
      penable = 1'b1;
      // Looking at pready mid-cycle avoids racing its update at the rising edge
      do begin
         @(negedge clock);
         n++;
      end while (pready !== 1'b1 && n < 20);
      @(negedge clock);
      psel = 1'b0;
      penable = 1'b0;
      // Released lines show a changed pattern so stale values are never trusted
      paddr = ~paddr;
      pwdata = ~pwdata;
   endtask
endmodule

/* File: tb.sv */
// Self-checking bench for the RTC: register traffic, ticks and interrupt outputs
`include "rcap_map.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic        chk;
      logic        err;
      logic [31:0] data;
   } rcap_note_type;

   logic          clock = 1'b0;
   logic          rstN = 1'b0;
   logic          rtcRstN = 1'b0;
   logic          tick = 1'b0;
   logic          stopMode = 1'b0;
   logic          psel;
   logic          penable;
   logic          pwrite;
   logic [7:0]    paddr;
   logic [31:0]   pwdata;
   logic [31:0]   prdata;
   logic          pready;
   logic          pslverr;
   logic          alarmIrq;
   logic          periodicIrq;
   rcap_note_type notes[$];
   rcap_note_type note;
   logic [47:0]   r;
   logic [47:0]   e;
   int            fail_count = 0;
   int            n_compared = 0;
   int            cycles = 0;

   always #10 clock = ~clock;

   rcap_rtc #(.TICKS_PER_SEC(4)) u_dut (
      .clock(clock), .rst_n(rstN), .rtc_domain_reset_n(rtcRstN), .tick_clock(tick),
      .stop_mode(stopMode), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .alarm_irq(alarmIrq), .periodic_irq(periodicIrq));

   rcap_apb_master u_mst (
      .clock(clock), .pready(pready), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata));

   task automatic final_report;
      if (notes.size() != 0) fail_count++;
      if (fail_count == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // Note the expected answer first, then hand the transfer to the master
   task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
                       input logic chk, input logic err);
      notes.push_back({chk, err, 16'h0000, d});
      u_mst.xfer(w, a, {16'h0000, d});
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      xfer(1'b1, a, d, 1'b0, 1'b0);
   endtask

   task automatic rd(input logic [7:0] a, input logic [15:0] d);
      xfer(1'b0, a, d, 1'b1, 1'b0);
   endtask

   // Tick high lasts four clocks and low five, so ticks run at a ninth of the bus rate
   task automatic ticks(input int n);
      repeat (n) begin
         @(negedge clock) tick = 1'b1;
         repeat (4) @(negedge clock);
         tick = 1'b0;
         repeat (4) @(negedge clock);
      end
   endtask

   // Oldest note is matched against every answered transfer
   always @(negedge clock) begin
      if (pready === 1'b1) begin
         if (notes.size() == 0) begin
            cmp(32'h0000_0001, 32'h0000_0000, "answer without request");
         end else begin
            note = notes.pop_front();
            cmp({31'h0, pslverr}, {31'h0, note.err}, "slave error");
            if (note.chk) cmp(prdata, note.data, "read data");
         end
      end
   end

   // Hang guard
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         final_report();
      end
   end

   initial begin
      void'($urandom(32'h12bc));
      r = {$urandom(), $urandom()};
      repeat (16) @(negedge clock);
      rstN = 1'b1;
      rtcRstN = 1'b1;
      rd(`RCAP_OFF_CTRL, 16'h0029);
      rd(`RCAP_OFF_COUNT_SLICE_MIDDLE, 16'h0000);
      rd(`RCAP_OFF_ALM_H, 16'hffff);
      rd(`RCAP_OFF_PER_L, 16'h8000);
      rd(`RCAP_OFF_PER_H, 16'h0000);
      xfer(1'b0, 8'h40, 16'h0000, 1'b1, 1'b1);
      wr(`RCAP_OFF_COUNT_SLICE_LOW, r[15:0]);
      rd(`RCAP_OFF_COUNT_SLICE_LOW, 16'h0000);
      wr(`RCAP_OFF_CTRL, 16'h0010);
      rd(`RCAP_OFF_CTRL, 16'h0039);
      wr(`RCAP_OFF_COUNT_SLICE_LOW, r[15:0]);
      wr(`RCAP_OFF_COUNT_SLICE_MIDDLE, r[31:16]);
      wr(`RCAP_OFF_COUNT_SLICE_HIGH, r[47:32]);
      e = r + 48'h3;
      wr(`RCAP_OFF_ALM_H, e[47:32]);
      wr(`RCAP_OFF_ALM_M, e[31:16]);
      wr(`RCAP_OFF_ALM_L, e[15:0]);
      wr(`RCAP_OFF_PER_L, 16'h0010);
      wr(`RCAP_OFF_PER_H, 16'h0000);
      rd(`RCAP_OFF_COUNT_SLICE_LOW, 16'h0000);
      wr(`RCAP_OFF_CTRL, 16'h0000);
      rd(`RCAP_OFF_CTRL, 16'h0009);
      wr(`RCAP_OFF_CTRL, 16'h0610);
      rd(`RCAP_OFF_CTRL, 16'h0009);
      ticks(2);
      rd(`RCAP_OFF_CTRL, 16'h0029);
      e = r + 48'h1;
      rd(`RCAP_OFF_COUNT_SLICE_LOW, e[15:0]);
      rd(`RCAP_OFF_COUNT_SLICE_MIDDLE, e[31:16]);
      rd(`RCAP_OFF_COUNT_SLICE_HIGH, e[47:32]);
      ticks(2);
      rd(`RCAP_OFF_CTRL, 16'h0029);
      ticks(1);
      rd(`RCAP_OFF_CTRL, 16'h002b);
      cmp({31'h0, alarmIrq}, 32'h0000_0000, "alarm irq masked");
      wr(`RCAP_OFF_CTRL, 16'h0202);
      ticks(2);
      rd(`RCAP_OFF_CTRL, 16'h022b);
      cmp({31'h0, alarmIrq}, 32'h0000_0001, "alarm irq enabled");
      wr(`RCAP_OFF_CTRL, 16'h0200);
      ticks(2);
      rd(`RCAP_OFF_CTRL, 16'h0229);
      cmp({31'h0, alarmIrq}, 32'h0000_0000, "alarm irq cleared");
      ticks(16);
      rd(`RCAP_OFF_CTRL, 16'h022d);
      cmp({31'h0, periodicIrq}, 32'h0000_0000, "periodic irq masked");
      wr(`RCAP_OFF_CTRL, 16'h0404);
      ticks(2);
      cmp({31'h0, periodicIrq}, 32'h0000_0001, "periodic irq enabled");
      // Stop mode turns the alarm into a fixed one-second timer
      stopMode = 1'b1;
      ticks(5);
      rd(`RCAP_OFF_CTRL, 16'h042f);
      final_report();
   end
endmodule
